//--- common/bridge_decode_cfg.svh
// Address map, register offsets and field positions of the memory decode block
`ifndef BRIDGE_DECODE_CFG_SVH
`define BRIDGE_DECODE_CFG_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_MEM_WINDOW 12'h000
`define OFS_PREFETCH_WINDOW 12'h004
`define OFS_BRIDGE_COMMAND 12'h008
`define OFS_MGMT_CONTROL 12'h00C
`define OFS_TOP_OF_DRAM 12'h010
`define OFS_SHADOW_CONTROL 12'h014
`define OFS_ERROR_STATUS 12'h018
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define WIN_BASE_LSB 0
`define WIN_LIMIT_LSB 16
`define CMD_MEM_ENABLE 1
`define MGMT_COMPAT_EN 0
`define MGMT_HIGH_EN 1
`define MGMT_TOP_EN 2
`define MGMT_OPEN 3
`define MGMT_CLOSE 4
`define MGMT_TOP_SIZE_LSB 5
`define TOD_LSB 17
`define SHADOW_READ_LSB 0
`define SHADOW_WRITE_LSB 4
`define ERR_INVALID_XLAT 0
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_WIN_BASE 12'hFFF
`define RST_WIN_LIMIT 12'h000
`define RST_TOD 15'h0000
`define RST_TOP_SIZE 2'h3
// ------------------------------------------------------------
// Address map
// ------------------------------------------------------------
`define FIRMWARE_BASE 32'hFFE0_0000
`define WIN_BASE_LOW 20'h0_0000
`define WIN_LIMIT_LOW 20'hF_FFFF
`define COMPAT_LOW 32'h000A_0000
`define COMPAT_HIGH 32'h000B_FFFF
`define HIGH_SEG_LOW 32'hFEDA_0000
`define HIGH_SEG_HIGH 32'hFEDB_FFFF
`define HIGH_SEG_OFS_MSB 16
`define SHADOW_LOW 32'h000C_0000
`define SHADOW_HIGH 32'h000F_FFFF
`define SHADOW_BLK_LSB 16
`define TOP_SIZE_MIN 32'h0002_0000
`define LARGE_DRAM 32'h1000_0000
`define ADDR_ZERO 32'h0000_0000
`define BE_NONE 4'h0
`endif

//--- common/bridge_decode_pkg.sv
// Types shared by the memory decode block
package bridge_decode_pkg;
  typedef enum logic [1:0] {SRC_CPU, SRC_HUB, SRC_GFX} requester_t;
  typedef enum logic [2:0] {TGT_DRAM, TGT_HUB, TGT_GFX, TGT_ROM, TGT_TERMINATE} route_target_t;
endpackage

//--- hdl/host_bridge_memory_decode_smm.sv
// Memory address decode and routing with management memory protection
//
// What this block does
// - Top 2 MB below 4 GB, the boot firmware region, goes to the hub link.
// - Accesses inside either graphics memory window go to the graphics port.
// - Window base and limit fields compare to A[31:20]; 1 MB granularity.
// - Graphics windows route nothing while the bridge memory enable bit is clear.
// - Three management regions: compatible, high segment and top segment.
// - Top segment sits at highest DRAM, 128 kB to 1 MB in size.
// - Hub and graphics masters never reach management memory, translated or not, except hub snoop writebacks.
// - Compatible and top segment accesses reach DRAM at the same address.
// - High segment addresses remap onto DRAM A0000h to BFFFFh.
// - Translated processor hits on management DRAM go to 0h, writes lose enables.
// - Any translated hit on management DRAM sets the invalid translation flag.
// - Translated graphics port hits on management DRAM go to 0h, writes unenabled.
// - Hub cycles are snooped first; snoop writebacks still reach management DRAM.
// - Translated hits on the high range go unremapped to DRAM with 256 MB installed.
// - Shadowed blocks: processor reads to ROM or DRAM, writes to ROM or DRAM, per block setting.
// - Non-management processor hits on top or high segment terminate unless open is set, except writebacks.
// - Other addresses above top of DRAM go to the hub link.
`timescale 1ns/10ps
`include "bridge_decode_cfg.svh"
`default_nettype none
module host_bridge_memory_decode_smm
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Request side
  input wire logic REQ_VALID,
  input wire bridge_decode_pkg::requester_t REQ_SRC,
  input wire logic [31:0] REQ_ADDR,
  input wire logic REQ_WRITE,
  input wire logic [3:0] REQ_BE,
  input wire logic REQ_TRANSLATED,
  input wire logic REQ_MGMT_MODE,
  input wire logic REQ_WRITEBACK,
  input wire logic REQ_SNOOP_WB,
  // Route side
  output logic RTE_VALID,
  output bridge_decode_pkg::route_target_t RTE_TARGET,
  output logic [31:0] RTE_ADDR,
  output logic [3:0] RTE_BE,
  output logic RTE_SNOOP
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [11:0] mem_window_base_q;
  logic [11:0] mem_window_limit_q;
  logic [11:0] prefetch_window_base_q;
  logic [11:0] prefetch_window_limit_q;
  logic mem_enable_q;
  logic compat_en_q;
  logic high_en_q;
  logic top_en_q;
  logic open_q;
  logic close_q;
  logic [1:0] top_segment_size_q;
  logic [14:0] top_of_dram_q;
  logic [3:0] shadow_read_q;
  logic [3:0] shadow_write_q;
  logic invalid_translation_flag_q;
  logic rte_valid_q;
  bridge_decode_pkg::route_target_t rte_target_q;
  logic [31:0] rte_addr_q;
  logic [3:0] rte_be_q;
  logic rte_snoop_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire logic apb_access = PSEL & PENABLE;
  wire logic apb_wr = apb_access & PWRITE;
  wire logic apb_rd = apb_access & ~PWRITE;
  wire logic sel_mem_win = PADDR == `OFS_MEM_WINDOW;
  wire logic sel_pf_win = PADDR == `OFS_PREFETCH_WINDOW;
  wire logic sel_cmd = PADDR == `OFS_BRIDGE_COMMAND;
  wire logic sel_mgmt = PADDR == `OFS_MGMT_CONTROL;
  wire logic sel_tod = PADDR == `OFS_TOP_OF_DRAM;
  wire logic sel_shadow = PADDR == `OFS_SHADOW_CONTROL;
  wire logic sel_err = PADDR == `OFS_ERROR_STATUS;
  wire logic sel_any = sel_mem_win | sel_pf_win | sel_cmd | sel_mgmt | sel_tod | sel_shadow | sel_err;
  wire logic [31:0] rd_mem_win = {4'h0, mem_window_limit_q, 4'h0, mem_window_base_q};
  wire logic [31:0] rd_pf_win = {4'h0, prefetch_window_limit_q, 4'h0, prefetch_window_base_q};
  wire logic [31:0] rd_cmd = {30'h0, mem_enable_q, 1'b0};
  wire logic [31:0] rd_mgmt = {25'h0, top_segment_size_q, close_q, open_q, top_en_q, high_en_q,
                               compat_en_q};
  wire logic [31:0] rd_tod = {top_of_dram_q, 17'h0_0000};
  wire logic [31:0] rd_shadow = {24'h0, shadow_write_q, shadow_read_q};
  wire logic [31:0] rd_err = {31'h0, invalid_translation_flag_q};
  wire logic [31:0] rd_mux = sel_mem_win ? rd_mem_win :
                             sel_pf_win ? rd_pf_win :
                             sel_cmd ? rd_cmd :
                             sel_mgmt ? rd_mgmt :
                             sel_tod ? rd_tod :
                             sel_shadow ? rd_shadow :
                             sel_err ? rd_err : 32'h0000_0000;

  assign PRDATA = apb_rd ? rd_mux : 32'h0000_0000;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access & ~sel_any;

  // ------------------------------------------------------------
  // Address classification
  // ------------------------------------------------------------
  wire logic [31:0] a = REQ_ADDR;
  wire logic [31:0] top_of_dram = {top_of_dram_q, 17'h0_0000};
  wire logic [31:0] top_size = `TOP_SIZE_MIN << top_segment_size_q;
  wire logic [31:0] top_base = top_of_dram - top_size;
  wire logic fw_hit = a >= `FIRMWARE_BASE;
  wire logic mem_win_hit = (a >= {mem_window_base_q, `WIN_BASE_LOW}) &&
                           (a <= {mem_window_limit_q, `WIN_LIMIT_LOW});
  wire logic pf_win_hit = (a >= {prefetch_window_base_q, `WIN_BASE_LOW}) &&
                          (a <= {prefetch_window_limit_q, `WIN_LIMIT_LOW});
  wire logic gfx_hit = mem_enable_q & (mem_win_hit | pf_win_hit);
  wire logic below_tod = a < top_of_dram;
  wire logic compat_hit = (a >= `COMPAT_LOW) && (a <= `COMPAT_HIGH);
  wire logic high_hit = high_en_q && (a >= `HIGH_SEG_LOW) && (a <= `HIGH_SEG_HIGH);
  wire logic top_hit = top_en_q && (a >= top_base) && below_tod;
  wire logic compat_en_hit = compat_en_q & compat_hit;
  wire logic shadow_hit = (a >= `SHADOW_LOW) && (a <= `SHADOW_HIGH);
  wire logic [1:0] shadow_blk = a[`SHADOW_BLK_LSB +: 2];
  wire logic large_dram = top_of_dram >= `LARGE_DRAM;
  wire logic mgmt_dram_hit = (compat_hit & (compat_en_q | high_en_q)) | top_hit;
  wire logic cpu_ok = open_q | (REQ_MGMT_MODE & ~close_q);
  wire logic is_cpu = REQ_SRC == bridge_decode_pkg::SRC_CPU;
  wire logic is_hub = REQ_SRC == bridge_decode_pkg::SRC_HUB;
  wire logic [31:0] high_remap = `COMPAT_LOW | {15'h0000, a[`HIGH_SEG_OFS_MSB:0]};
  wire logic [3:0] invalid_be = REQ_WRITE ? `BE_NONE : REQ_BE;

  // ------------------------------------------------------------
  // Route selection
  // ------------------------------------------------------------
  bridge_decode_pkg::route_target_t tgt_d;
  logic [31:0] addr_d;
  logic [3:0] be_d;
  logic flag_set;

  always_comb
  begin
    tgt_d = bridge_decode_pkg::TGT_DRAM;
    addr_d = a;
    be_d = REQ_BE;
    flag_set = 1'b0;
    if (REQ_TRANSLATED && high_hit && large_dram)
    begin
      tgt_d = bridge_decode_pkg::TGT_DRAM;
    end
    else if (REQ_TRANSLATED && mgmt_dram_hit)
    begin
      flag_set = 1'b1;
      if (!(is_hub && REQ_SNOOP_WB))
      begin
        addr_d = `ADDR_ZERO;
        be_d = invalid_be;
      end
    end
    else if (high_hit)
    begin
      if (!is_cpu)
      begin
        addr_d = (is_hub && REQ_SNOOP_WB) ? high_remap : `ADDR_ZERO;
        be_d = (is_hub && REQ_SNOOP_WB) ? REQ_BE : invalid_be;
      end
      else if (cpu_ok || REQ_WRITEBACK)
        addr_d = high_remap;
      else
        tgt_d = bridge_decode_pkg::TGT_TERMINATE;
    end
    else if (top_hit || compat_en_hit)
    begin
      if (!is_cpu)
      begin
        if (!(is_hub && REQ_SNOOP_WB))
        begin
          addr_d = `ADDR_ZERO;
          be_d = invalid_be;
        end
      end
      else if (compat_en_hit && !cpu_ok)
        tgt_d = bridge_decode_pkg::TGT_HUB;
      else if (top_hit && !cpu_ok && !REQ_WRITEBACK)
        tgt_d = bridge_decode_pkg::TGT_TERMINATE;
      else
        tgt_d = bridge_decode_pkg::TGT_DRAM;
    end
    else if (compat_hit)
      tgt_d = bridge_decode_pkg::TGT_HUB;
    else if (shadow_hit && is_cpu)
    begin
      if (REQ_WRITE)
        tgt_d = shadow_write_q[shadow_blk] ? bridge_decode_pkg::TGT_DRAM
                                           : bridge_decode_pkg::TGT_ROM;
      else
        tgt_d = shadow_read_q[shadow_blk] ? bridge_decode_pkg::TGT_DRAM
                                          : bridge_decode_pkg::TGT_ROM;
    end
    else if (fw_hit)
      tgt_d = bridge_decode_pkg::TGT_HUB;
    else if (gfx_hit)
      tgt_d = bridge_decode_pkg::TGT_GFX;
    else if (!below_tod)
      tgt_d = bridge_decode_pkg::TGT_HUB;
  end

  // ------------------------------------------------------------
  // Register write and status
  // ------------------------------------------------------------
  wire logic flag_hit = REQ_VALID & flag_set;
  wire logic flag_clr = apb_wr & sel_err & PWDATA[`ERR_INVALID_XLAT];

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      mem_window_base_q <= `RST_WIN_BASE;
      mem_window_limit_q <= `RST_WIN_LIMIT;
      prefetch_window_base_q <= `RST_WIN_BASE;
      prefetch_window_limit_q <= `RST_WIN_LIMIT;
      mem_enable_q <= 1'b0;
      {compat_en_q, high_en_q, top_en_q, open_q, close_q} <= 5'h00;
      top_segment_size_q <= `RST_TOP_SIZE;
      top_of_dram_q <= `RST_TOD;
      shadow_read_q <= 4'h0;
      shadow_write_q <= 4'h0;
    end
    else if (apb_wr)
    begin
      if (sel_mem_win)
      begin
        mem_window_base_q <= PWDATA[`WIN_BASE_LSB +: 12];
        mem_window_limit_q <= PWDATA[`WIN_LIMIT_LSB +: 12];
      end
      if (sel_pf_win)
      begin
        prefetch_window_base_q <= PWDATA[`WIN_BASE_LSB +: 12];
        prefetch_window_limit_q <= PWDATA[`WIN_LIMIT_LSB +: 12];
      end
      if (sel_cmd)
        mem_enable_q <= PWDATA[`CMD_MEM_ENABLE];
      if (sel_mgmt)
      begin
        compat_en_q <= PWDATA[`MGMT_COMPAT_EN];
        high_en_q <= PWDATA[`MGMT_HIGH_EN];
        top_en_q <= PWDATA[`MGMT_TOP_EN];
        open_q <= PWDATA[`MGMT_OPEN];
        close_q <= PWDATA[`MGMT_CLOSE];
        top_segment_size_q <= PWDATA[`MGMT_TOP_SIZE_LSB +: 2];
      end
      if (sel_tod)
        top_of_dram_q <= PWDATA[`TOD_LSB +: 15];
      if (sel_shadow)
      begin
        shadow_read_q <= PWDATA[`SHADOW_READ_LSB +: 4];
        shadow_write_q <= PWDATA[`SHADOW_WRITE_LSB +: 4];
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge MCLK)
  begin
    if (RST)
      invalid_translation_flag_q <= 1'b0;
    else if (flag_hit)
      invalid_translation_flag_q <= 1'b1;
    else if (flag_clr)
      invalid_translation_flag_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Route output stage
  // ------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rte_valid_q <= 1'b0;
      rte_target_q <= bridge_decode_pkg::TGT_DRAM;
      rte_addr_q <= `ADDR_ZERO;
      rte_be_q <= `BE_NONE;
      rte_snoop_q <= 1'b0;
    end
    else
    begin
      rte_valid_q <= REQ_VALID;
      rte_target_q <= tgt_d;
      rte_addr_q <= addr_d;
      rte_be_q <= be_d;
      rte_snoop_q <= REQ_VALID & is_hub;
    end
  end

  assign RTE_VALID = rte_valid_q;
  assign RTE_TARGET = rte_target_q;
  assign RTE_ADDR = rte_addr_q;
  assign RTE_BE = rte_be_q;
  assign RTE_SNOOP = rte_snoop_q;
endmodule
`default_nettype wire

//--- testbench/host_bridge_memory_decode_smm_props.sv
// Port-level assertions for the memory decode block
`timescale 1ns/10ps
`include "bridge_decode_cfg.svh"
`default_nettype none
module host_bridge_memory_decode_smm_props
(
  // Clock, reset and register port
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  // Requests
  input wire logic REQ_VALID,
  input wire bridge_decode_pkg::requester_t REQ_SRC,
  input wire logic [31:0] REQ_ADDR,
  input wire logic REQ_WRITE,
  input wire logic REQ_TRANSLATED,
  input wire logic REQ_MGMT_MODE,
  input wire logic REQ_WRITEBACK,
  input wire logic REQ_SNOOP_WB,
  // Routes
  input wire logic RTE_VALID,
  input wire bridge_decode_pkg::route_target_t RTE_TARGET,
  input wire logic [31:0] RTE_ADDR,
  input wire logic [3:0] RTE_BE,
  input wire logic RTE_SNOOP
);
  logic [6:0] mgmt_q;
  logic memen_q;
  wire logic cfg_wr = PSEL && PENABLE && PWRITE && PREADY;
  wire logic cmp_hit = REQ_ADDR >= `COMPAT_LOW && REQ_ADDR <= `COMPAT_HIGH;
  wire logic high_hit = REQ_ADDR >= `HIGH_SEG_LOW && REQ_ADDR <= `HIGH_SEG_HIGH;
  // ----------------------------------------
  // Copies of the protection settings and the bridge memory enable bit
  // ----------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
      mgmt_q <= 7'h60;
    else if (cfg_wr && PADDR == `OFS_MGMT_CONTROL)
      mgmt_q <= PWDATA[6:0];
  end
  always_ff @(posedge MCLK)
  begin
    if (RST)
      memen_q <= 1'b0;
    else if (cfg_wr && PADDR == `OFS_BRIDGE_COMMAND)
      memen_q <= PWDATA[`CMD_MEM_ENABLE];
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence s_cpu_high;
    REQ_VALID && REQ_SRC == bridge_decode_pkg::SRC_CPU && high_hit && !REQ_TRANSLATED && mgmt_q[1];
  endsequence
  sequence s_guard;
    REQ_VALID && REQ_SRC != bridge_decode_pkg::SRC_CPU && !REQ_SNOOP_WB && cmp_hit && mgmt_q[0];
  endsequence
  property p_fw;
    REQ_VALID && REQ_ADDR >= `FIRMWARE_BASE |=> RTE_TARGET == bridge_decode_pkg::TGT_HUB;
  endproperty
  a_fw: assert property (p_fw) else $error("firmware access not sent to hub");
  property p_gfx_off;
    REQ_VALID && !memen_q |=> RTE_VALID && RTE_TARGET != bridge_decode_pkg::TGT_GFX;
  endproperty
  a_gfx_off: assert property (p_gfx_off) else $error("graphics route while disabled");
  property p_snoop;
    REQ_VALID && REQ_SRC == bridge_decode_pkg::SRC_HUB |=> RTE_VALID && RTE_SNOOP;
  endproperty
  a_snoop: assert property (p_snoop) else $error("hub cycle not snooped");
  property p_high_remap;
    s_cpu_high ##0 (REQ_MGMT_MODE && !mgmt_q[4]) |=> RTE_TARGET == bridge_decode_pkg::TGT_DRAM
      && RTE_ADDR == (`COMPAT_LOW | ($past(REQ_ADDR) & 32'h0001_FFFF));
  endproperty
  a_high_remap: assert property (p_high_remap) else $error("high segment remap wrong");
  property p_high_term;
    s_cpu_high ##0 (!REQ_MGMT_MODE && !mgmt_q[3] && !REQ_WRITEBACK)
      |=> RTE_TARGET == bridge_decode_pkg::TGT_TERMINATE;
  endproperty
  a_high_term: assert property (p_high_term) else $error("high segment not terminated");
  property p_guard;
    s_guard |=> RTE_TARGET == bridge_decode_pkg::TGT_DRAM && RTE_ADDR == `ADDR_ZERO;
  endproperty
  a_guard: assert property (p_guard) else $error("outside master reached mgmt memory");
  property p_be;
    s_guard ##0 REQ_WRITE |=> RTE_BE == `BE_NONE;
  endproperty
  a_be: assert property (p_be) else $error("blocked write kept byte enables");
  property p_compat;
    REQ_VALID && REQ_SRC == bridge_decode_pkg::SRC_CPU && cmp_hit && mgmt_q[0] && REQ_MGMT_MODE
      && !mgmt_q[4] && !REQ_TRANSLATED
      |=> RTE_TARGET == bridge_decode_pkg::TGT_DRAM && RTE_ADDR == $past(REQ_ADDR);
  endproperty
  a_compat: assert property (p_compat) else $error("compatible access remapped");
endmodule
bind host_bridge_memory_decode_smm host_bridge_memory_decode_smm_props u_props
(
  .MCLK, .RST, .PSEL, .PENABLE, .PWRITE, .PREADY, .PADDR, .PWDATA, .REQ_VALID, .REQ_SRC,
  .REQ_ADDR, .REQ_WRITE, .REQ_TRANSLATED, .REQ_MGMT_MODE, .REQ_WRITEBACK, .REQ_SNOOP_WB,
  .RTE_VALID, .RTE_TARGET, .RTE_ADDR, .RTE_BE, .RTE_SNOOP
);
`default_nettype wire

//--- testbench/req_masters_model.sv
// Processor, hub and graphics requesters facing the decode block
`timescale 1ns/10ps
`default_nettype none
module req_masters_model
(
  // Clock
  input wire logic mclk,
  // Request port
  output logic req_valid,
  output bridge_decode_pkg::requester_t req_src,
  output logic [31:0] req_addr,
  output logic [3:0] req_be,
  output logic req_write,
  output logic req_translated,
  output logic req_mgmt_mode,
  output logic req_writeback,
  output logic req_snoop_wb
);
  initial
  begin
    req_valid = 1'b0;
    req_src = bridge_decode_pkg::SRC_CPU;
    req_addr = 32'h0000_0000;
    req_be = 4'h0;
    {req_write, req_translated, req_mgmt_mode, req_writeback, req_snoop_wb} = 5'h00;
  end
  // One request for one cycle; flags are write, translated, mode, writeback, snoop
  task automatic issue(input bridge_decode_pkg::requester_t s, input logic [31:0] a,
      input logic [3:0] be, input logic [4:0] f);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_src <= s;
    req_addr <= a;
    req_be <= be;
    {req_write, req_mgmt_mode, req_writeback, req_snoop_wb} <= {f[4], f[2:0]};
    req_translated <= f[3] && (a < 32'h000A_0000 || a > 32'h000F_FFFF);
    @(posedge mclk);
    req_valid <= 1'b0;
    req_addr <= ~a;
    req_be <= ~be;
  endtask
endmodule
`default_nettype wire

//--- testbench/test_host_bridge_memory_decode_smm.sv
// Self-checking bench for the memory decode block
`timescale 1ns/10ps
`include "bridge_decode_cfg.svh"
`default_nettype none
module test_host_bridge_memory_decode_smm;
  localparam bridge_decode_pkg::requester_t s_cpu = bridge_decode_pkg::SRC_CPU;
  localparam bridge_decode_pkg::requester_t s_hub = bridge_decode_pkg::SRC_HUB;
  localparam bridge_decode_pkg::requester_t s_gfx = bridge_decode_pkg::SRC_GFX;
  localparam bridge_decode_pkg::route_target_t t_dram = bridge_decode_pkg::TGT_DRAM;
  localparam bridge_decode_pkg::route_target_t t_hub = bridge_decode_pkg::TGT_HUB;
  localparam bridge_decode_pkg::route_target_t t_gfx = bridge_decode_pkg::TGT_GFX;
  localparam bridge_decode_pkg::route_target_t t_rom = bridge_decode_pkg::TGT_ROM;
  localparam bridge_decode_pkg::route_target_t t_term = bridge_decode_pkg::TGT_TERMINATE;
  typedef struct packed {bridge_decode_pkg::route_target_t t; logic [31:0] a;
    logic [3:0] b; logic s;} note_t;
  note_t rq_q[$];
  logic [32:0] ap_q[$];
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, req_addr, rte_addr;
  logic req_valid, req_write, req_translated, req_mgmt_mode, req_writeback, req_snoop_wb;
  logic [3:0] req_be, rte_be;
  logic rte_valid, rte_snoop;
  bridge_decode_pkg::requester_t req_src;
  bridge_decode_pkg::route_target_t rte_target;
  host_bridge_memory_decode_smm DUT
  (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REQ_VALID(req_valid), .REQ_SRC(req_src), .REQ_ADDR(req_addr), .REQ_WRITE(req_write),
    .REQ_BE(req_be), .REQ_TRANSLATED(req_translated), .REQ_MGMT_MODE(req_mgmt_mode),
    .REQ_WRITEBACK(req_writeback), .REQ_SNOOP_WB(req_snoop_wb), .RTE_VALID(rte_valid),
    .RTE_TARGET(rte_target), .RTE_ADDR(rte_addr), .RTE_BE(rte_be), .RTE_SNOOP(rte_snoop)
  );
  req_masters_model mst
  (
    .mclk(mclk), .req_valid(req_valid), .req_src(req_src), .req_addr(req_addr),
    .req_be(req_be), .req_write(req_write), .req_translated(req_translated),
    .req_mgmt_mode(req_mgmt_mode), .req_writeback(req_writeback), .req_snoop_wb(req_snoop_wb)
  );
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic fail(input string m);
    n_errors++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_route(input note_t e);
    tests_run++;
    if (rte_target !== e.t || rte_snoop !== e.s || (e.t != t_term && {rte_addr, rte_be} !== {e.a, e.b}))
      fail("route differs from expected");
  endtask
  task automatic cmp_apb(input logic [32:0] e);
    tests_run++;
    if ({prdata, pslverr} !== e)
      fail("register access differs from expected");
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail("run did not finish");
      give_verdict();
    end
    else
    begin
      if (rte_valid === 1'b1)
        cmp_route(rq_q.size() ? rq_q.pop_front() : note_t'('1));
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        cmp_apb(ap_q.size() ? ap_q.pop_front() : 33'h1_FFFF_FFFF);
    end
  end
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge mclk);
    ap_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, {x, 1'b0});
  endtask
  task automatic rq(input bridge_decode_pkg::requester_t s, input logic [31:0] a, input logic [4:0] f,
      input bridge_decode_pkg::route_target_t t, input logic [31:0] ea, input logic z);
    logic [3:0] be;
    be = 4'($urandom);
    rq_q.push_back({t, ea, z ? 4'h0 : be, s == s_hub});
    mst.issue(s, a, be, f);
  endtask
  task automatic rr(input bridge_decode_pkg::requester_t s, input logic [31:0] a, input logic [4:0] f,
      input bridge_decode_pkg::route_target_t t);
    rq(s, a, f, t, a, 1'b0);
  endtask
  initial
  begin
    logic [31:0] a;
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0000_0000};
    void'($urandom(32'h1858_e5c9));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(`OFS_MEM_WINDOW, 32'h0000_0FFF);
    rd(`OFS_MGMT_CONTROL, 32'h0000_0060);
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF, 33'h0_0000_0001);
    apb(1'b0, 12'h01C, 32'h0000_0000, 33'h0_0000_0001);
    wr(`OFS_MEM_WINDOW, 32'h080F_0800);
    wr(`OFS_PREFETCH_WINDOW, 32'h0900_0900);
    wr(`OFS_MGMT_CONTROL, 32'h0000_0007);
    wr(`OFS_TOP_OF_DRAM, 32'h1000_0000);
    wr(`OFS_SHADOW_CONTROL, 32'h0000_0021);
    rr(s_cpu, 32'h8000_0000, 5'h00, t_hub);
    wr(`OFS_BRIDGE_COMMAND, 32'h0000_0002);
    rr(s_cpu, 32'h8000_0000, 5'h00, t_gfx);
    rr(s_hub, 32'h80FF_FFFF, 5'h00, t_gfx);
    rr(s_cpu, 32'h8100_0000, 5'h00, t_hub);
    rr(s_cpu, 32'h7FFF_FFFF, 5'h00, t_hub);
    rr(s_cpu, 32'h900F_FFFF, 5'h00, t_gfx);
    repeat (3)
    begin
      a = {11'h7FF, 21'($urandom)};
      rr(s_cpu, a, 5'h00, t_hub);
    end
    rr(s_cpu, 32'h0FFD_FFFF, 5'h00, t_dram);
    rr(s_cpu, 32'h0FFE_0000, 5'h04, t_dram);
    rr(s_cpu, 32'h0FFF_FFFC, 5'h00, t_term);
    rr(s_cpu, 32'h0FFE_0040, 5'h12, t_dram);
    rr(s_cpu, 32'h000A_0010, 5'h04, t_dram);
    rr(s_cpu, 32'h000B_0000, 5'h00, t_hub);
    rq(s_hub, 32'h000A_0010, 5'h00, t_dram, 32'h0000_0000, 1'b0);
    rq(s_gfx, 32'h000B_FFFC, 5'h10, t_dram, 32'h0000_0000, 1'b1);
    rq(s_cpu, 32'hFEDA_1234, 5'h04, t_dram, 32'h000A_1234, 1'b0);
    rq(s_cpu, 32'hFEDB_FFFC, 5'h14, t_dram, 32'h000B_FFFC, 1'b0);
    rr(s_cpu, 32'hFEDA_0000, 5'h00, t_term);
    rq(s_cpu, 32'hFEDA_0008, 5'h12, t_dram, 32'h000A_0008, 1'b0);
    rq(s_gfx, 32'hFEDA_0000, 5'h00, t_dram, 32'h0000_0000, 1'b0);
    rd(`OFS_ERROR_STATUS, 32'h0000_0000);
    rq(s_cpu, 32'h0FFE_0100, 5'h18, t_dram, 32'h0000_0000, 1'b1);
    rd(`OFS_ERROR_STATUS, 32'h0000_0001);
    wr(`OFS_ERROR_STATUS, 32'h0000_0001);
    rd(`OFS_ERROR_STATUS, 32'h0000_0000);
    rq(s_gfx, 32'h0FFF_0000, 5'h08, t_dram, 32'h0000_0000, 1'b0);
    rq(s_hub, 32'h0FFE_0200, 5'h18, t_dram, 32'h0000_0000, 1'b1);
    rr(s_hub, 32'h0FFE_0300, 5'h19, t_dram);
    rd(`OFS_ERROR_STATUS, 32'h0000_0001);
    rr(s_cpu, 32'hFEDA_0040, 5'h08, t_dram);
    rd(`OFS_PREFETCH_WINDOW, 32'h0900_0900);
    wr(`OFS_MGMT_CONTROL, 32'h0000_006F);
    rr(s_cpu, 32'h0FEF_FFFF, 5'h00, t_dram);
    rr(s_cpu, 32'h0FF0_0000, 5'h00, t_dram);
    rq(s_hub, 32'hFEDA_0100, 5'h01, t_dram, 32'h000A_0100, 1'b0);
    wr(`OFS_MGMT_CONTROL, 32'h0000_0077);
    rr(s_cpu, 32'h0FF0_0000, 5'h04, t_term);
    wr(`OFS_TOP_OF_DRAM, 32'h0FE0_0000);
    rr(s_cpu, 32'hFEDA_0040, 5'h08, t_term);
    rr(s_cpu, 32'h000C_0000, 5'h00, t_dram);
    rr(s_cpu, 32'h000D_0000, 5'h00, t_rom);
    rr(s_cpu, 32'h000D_0004, 5'h10, t_dram);
    rr(s_cpu, 32'h000C_0004, 5'h10, t_rom);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(`OFS_TOP_OF_DRAM, 32'h0000_0000);
    rr(s_cpu, 32'h8000_0000, 5'h00, t_hub);
    repeat (3) @(posedge mclk);
    if (rq_q.size() != 0 || ap_q.size() != 0)
      fail("expected results never appeared");
    give_verdict();
  end
endmodule
`default_nettype wire
